// File: src/bds_pkg.sv
// Constants shared by the burst-of-four SRAM command port
package bds_pkg;
  // ***********************************************
  // Data and burst shape
  // ***********************************************
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int BURST_LEN = 4;
  localparam logic [1:0] BURST_LAST = 2'h3;
  localparam logic [1:0] BURST_FIRST = 2'h0;
  localparam logic [1:0] LANE_ABORT = 2'h3;
  // ***********************************************
  // Sizes and margins
  // ***********************************************
  localparam int ADDR_W_DEF = 6;
  localparam int FIFO_DEPTH = 32;
  // Room for the burst being captured plus one more
  localparam int FIFO_HEADROOM = 2 * BURST_LEN;
  localparam int CLK_PERIOD_NS = 40;
  // Pin level after reset: selects idle, clock running
  localparam logic SYNC_RESET_LEVEL = 1'b1;
endpackage : bds_pkg

// File: src/bds_fifo_if.sv
// Handshake bundle between the command port and its write FIFO
`timescale 1ns/1ns
interface bds_fifo_if #(
  parameter int W = 26,
  parameter int LW = 6
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic [LW-1:0] level;
  modport fifo (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data, level
  );
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data, level
  );
endinterface : bds_fifo_if

// File: src/bds_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
module bds_fifo #(
  parameter int W = 26,
  parameter int DEPTH = bds_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,         // System clock
  input wire logic rst_b_i,       // Synchronous reset, active low
  bds_fifo_if.fifo port_f         // Fill and drain sides
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] store [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic [PW:0] fill;
  logic push;
  logic pop;

  // ***********************************************
  // Flags
  // ***********************************************
  // Extra pointer bit tells full from empty
  assign fill = wr_ptr - rd_ptr;
  // Full count needs the extra pointer bit, or it folds onto empty
  assign port_f.in_ready = (fill != (PW+1)'(DEPTH));
  assign port_f.out_valid = (fill != '0);
  assign port_f.level = fill;
  assign push = port_f.in_valid & port_f.in_ready;
  assign pop = port_f.out_valid & port_f.out_ready;
  assign port_f.out_data = store[rd_ptr[PW-1:0]];

  // Pointer update
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (push)
      store[wr_ptr[PW-1:0]] <= port_f.in_data;
  end
endmodule : bds_fifo

// File: src/bds_sram_port.sv
// Burst-of-four DDR SRAM command port with late write and byte lanes
`timescale 1ns/1ns
// Contract
// R1: Every access moves exactly four words.
// R2: Burst addresses run base, +1, +2, +3.
// R3: Read select low at K edge starts read.
// R4: Write select low at K edge starts write.
// R5: Controller spaces same commands two K edges.
// R6: Back-to-back same command: second is dropped.
// R7: Both selects after no-op: read wins.
// R8: Read words at t+1.5, 2.0, 2.5, 3.0. Code drives them at t+2.0, 2.5, 3.0, 3.5 (steps 4 to 7).
// R9: Write words at t+1.0 through t+2.5.
// R10: No-op keeps burst; idle output released.
// R11: Controller completes bursts before stopping clocks.
// R12: Lane select low stores that lane only.
// R13: Stopped clock holds state, ignores commands.
module bds_sram_port #(
  parameter int AW = bds_pkg::ADDR_W_DEF,
  parameter int DEPTH = bds_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,                   // Half-cycle clock, 25 MHz
  input wire logic rst_b_i,                 // Synchronous reset, low
  input wire logic clk_run_i,               // High while K pair toggles
  input wire logic read_sel_n_i,            // Read select, active low
  input wire logic write_sel_n_i,           // Write select, active low
  input wire logic [AW-1:0] addr_i,         // Burst start address
  input wire logic [17:0] wdata_i,          // Write data word
  input wire logic byte_lane0_write_n_i,    // Lane 0 write, active low
  input wire logic byte_lane1_write_n_i,    // Lane 1 write, active low
  output logic [17:0] rdata_o,              // Read data word
  output logic rdata_oe_o                   // Read data driven
);
  localparam int DW = bds_pkg::DATA_W;
  localparam int SW = 3 + AW + DW + 2;
  localparam int FW = AW + 2 + DW;
  localparam int LW = $clog2(DEPTH) + 1;

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic run;
  logic rsel_n;
  logic wsel_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [1:0] lane_n;

  // Two stages before any logic looks at a pin
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sync1 <= {SW{bds_pkg::SYNC_RESET_LEVEL}};
      sync2 <= {SW{bds_pkg::SYNC_RESET_LEVEL}};
    end
    else
    begin
      sync1 <= {clk_run_i, read_sel_n_i, write_sel_n_i, addr_i, wdata_i,
                byte_lane1_write_n_i, byte_lane0_write_n_i};
      sync2 <= sync1;
    end
  end
  assign {run, rsel_n, wsel_n, addr, wdata, lane_n} = sync2;

  // ***********************************************
  // Command decode
  // ***********************************************
  logic phase;
  logic k_edge;
  logic prev_nop;
  logic last_rd;
  logic last_wr;
  logic acc_rd;
  logic acc_wr;
  logic room;
  bds_fifo_if #(.W(FW), .LW(LW)) wq ();

  // Phase 0 is a K rise, phase 1 a K# rise; frozen when stopped
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      phase <= 1'b0;
    // R13: stopped clock freezes
    else if (run)
      phase <= ~phase;
  end
  assign k_edge = run & ~phase;
  // Keep space for a full burst; pins cannot be stalled
  assign room = wq.level <= LW'(DEPTH - bds_pkg::FIFO_HEADROOM);
  // R3: read on K edge
  // R6: drop back-to-back read
  assign acc_rd = k_edge & ~rsel_n & ~last_rd;
  // R4: write on K edge
  // R7: read wins after no-op
  assign acc_wr = k_edge & ~wsel_n & ~last_wr & room
                  & ~(~rsel_n & prev_nop);

  // History of the previous K edge
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      prev_nop <= 1'b1;
      last_rd <= 1'b0;
      last_wr <= 1'b0;
    end
    else if (k_edge)
    begin
      prev_nop <= rsel_n & wsel_n;
      last_rd <= acc_rd;
      last_wr <= acc_wr;
    end
  end

  // ***********************************************
  // Read path
  // ***********************************************
  logic [DW-1:0] mem [2**AW];
  logic s1;
  logic s2;
  logic [AW-1:0] s1_a;
  logic [AW-1:0] s2_a;
  logic f_v;
  logic [1:0] f_k;
  logic [AW-1:0] f_a;

  // Two-step latency, then four fetches; next read may overlap tail
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      f_v <= 1'b0;
      f_k <= bds_pkg::BURST_FIRST;
      s1_a <= '0;
      s2_a <= '0;
      f_a <= '0;
    end
    else if (run)
    begin
      s1 <= acc_rd;
      s1_a <= addr;
      s2 <= s1;
      s2_a <= s1_a;
      // R1: exactly four fetches
      f_v <= s2 | (f_v & (f_k != bds_pkg::BURST_LAST));
      if (s2)
      begin
        f_k <= bds_pkg::BURST_FIRST;
        f_a <= s2_a;
      end
      // R2: linear increment
      else if (f_v)
        f_k <= f_k + 2'h1;
    end
  end

  // Output register, one word per half cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= '0;
      rdata_oe_o <= 1'b0;
    end
    else if (run)
    begin
      // R8: words at steps 4 to 7
      // R10: released when none due
      rdata_oe_o <= f_v;
      if (f_v)
        rdata_o <= mem[f_a + AW'(f_k)];
    end
  end

  // ***********************************************
  // Write path
  // ***********************************************
  logic wb;
  logic [AW-1:0] wb_a;
  logic wc_v;
  logic [1:0] wc_k;
  logic [AW-1:0] wc_a;
  logic [FW-1:0] drain;

  // Capture window opens one K cycle after the command
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      wb <= 1'b0;
      wb_a <= '0;
      wc_v <= 1'b0;
      wc_k <= bds_pkg::BURST_FIRST;
      wc_a <= '0;
    end
    else if (run)
    begin
      wb <= acc_wr;
      wb_a <= addr;
      // R9: four late-write words
      wc_v <= wb | (wc_v & (wc_k != bds_pkg::BURST_LAST));
      if (wb)
      begin
        wc_k <= bds_pkg::BURST_FIRST;
        wc_a <= wb_a;
      end
      else if (wc_v)
        wc_k <= wc_k + 2'h1;
    end
  end

  // R12: aborted words never queued
  assign wq.in_valid = run & wc_v & (lane_n != bds_pkg::LANE_ABORT);
  assign wq.in_data = {wc_a + AW'(wc_k), lane_n, wdata};
  // Array is single ported: reads take priority over draining
  assign wq.out_ready = run & ~f_v;
  assign drain = wq.out_data;

  bds_fifo #(.W(FW), .DEPTH(DEPTH)) u_wq (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .port_f(wq)
  );

  // R12: per-lane array update
  always_ff @(posedge clk_i)
  begin
    if (wq.out_valid & wq.out_ready)
    begin
      for (int l = 0; l < bds_pkg::LANES; l++)
      begin
        if (!drain[DW+l])
          mem[drain[FW-1-:AW]][l*bds_pkg::LANE_W+:bds_pkg::LANE_W] <=
            drain[l*bds_pkg::LANE_W+:bds_pkg::LANE_W];
      end
    end
  end

  // ***********************************************
  // Checks
  // ***********************************************
  logic [7:0] run_hist;
  logic steady;

  // Run history so timing checks skip stopped windows
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      run_hist <= '0;
    else
      run_hist <= {run_hist[6:0], run};
  end
  assign steady = (&run_hist) & run;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_rd_kick;
    acc_rd ##1 run ##1 run;
  endsequence
  sequence s_fetch_next;
    f_v && (f_k == $past(f_k) + 2'h1);
  endsequence

  property p_burst_len;
    run && f_v && f_k == bds_pkg::BURST_LAST && !s2 |=> !f_v;
  endproperty
  a_burst_len: assert property (p_burst_len) // R1
    else $error("read burst longer than four words");
  property p_linear;
    run && f_v && f_k != bds_pkg::BURST_LAST && !s2 |=> s_fetch_next;
  endproperty
  a_linear: assert property (p_linear) // R2
    else $error("burst address not linear");
  property p_rd_start;
    s_rd_kick |=> f_v && f_k == bds_pkg::BURST_FIRST;
  endproperty
  a_rd_start: assert property (p_rd_start) // R3
    else $error("accepted read did not start fetch");
  property p_wr_start;
    acc_wr ##1 run |=> wc_v && wc_k == bds_pkg::BURST_FIRST;
  endproperty
  a_wr_start: assert property (p_wr_start) // R4
    else $error("accepted write did not open capture");
  property p_same_gap;
    (acc_rd |-> ##2 !acc_rd) and (acc_wr |-> ##2 !acc_wr);
  endproperty
  a_same_gap: assert property (p_same_gap) // R6
    else $error("back-to-back command accepted");
  property p_rw_collide;
    k_edge && !rsel_n && !wsel_n && prev_nop |-> acc_rd && !acc_wr;
  endproperty
  a_rw_collide: assert property (p_rw_collide) // R7
    else $error("write not dropped after no-op");
  property p_rd_timing;
    steady && ($past(acc_rd, 4) || $past(acc_rd, 7)) |-> rdata_oe_o;
  endproperty
  a_rd_timing: assert property (p_rd_timing) // R8
    else $error("read word missing at its slot");
  property p_wr_words;
    steady && $past(acc_wr, 5) |-> wc_v && wc_k == bds_pkg::BURST_LAST;
  endproperty
  a_wr_words: assert property (p_wr_words) // R9
    else $error("fourth write word not at its slot");
  property p_rd_idle;
    run && !f_v |=> !rdata_oe_o;
  endproperty
  a_rd_idle: assert property (p_rd_idle) // R10
    else $error("read output driven with no word due");
  property p_abort;
    run && wc_v && lane_n == bds_pkg::LANE_ABORT |-> !wq.in_valid;
  endproperty
  a_abort: assert property (p_abort) // R12
    else $error("aborted word queued");
  property p_stop_hold;
    !run |=> $stable(rdata_o) && $stable(rdata_oe_o) && $stable(f_k);
  endproperty
  a_stop_hold: assert property (p_stop_hold) // R13
    else $error("state changed while clock stopped");
endmodule : bds_sram_port

// File: sim/bds_ctrl_model.sv
// Memory controller model driving commands and late write data
`timescale 1ns/1ns
module bds_ctrl_model (
  input wire logic clk_i,           // System clock
  input wire logic go_i,            // Issue one command
  input wire logic rd_i,            // Ask for a read
  input wire logic wr_i,            // Ask for a write
  input wire logic [5:0] addr_i,    // Burst start address
  input wire logic [71:0] words_i,  // Four write words
  input wire logic [7:0] lanes_n_i, // Lane selects, two per word
  output logic read_sel_n_o,        // Read select pin
  output logic write_sel_n_o,       // Write select pin
  output logic [5:0] addr_o,        // Address pin
  output logic [17:0] wdata_o,      // Write data pin
  output logic [1:0] lanes_n_o      // Lane select pins
);
  int slot = 9;
  // Idle pins at time zero
  initial
  begin
    read_sel_n_o = 1'b1;
    write_sel_n_o = 1'b1;
    addr_o = 6'h00;
    wdata_o = 18'h00000;
    lanes_n_o = 2'h3;
  end
  // one-cycle selects, spacing kept by caller
  always @(posedge clk_i)
  begin
    read_sel_n_o <= !(go_i && rd_i);
    write_sel_n_o <= !(go_i && wr_i);
    // Address not held past its command, so it toggles
    addr_o <= go_i ? addr_i : ~addr_o;
    slot <= go_i ? 0 : slot + 1;
  end
  // one word per half cycle, one cycle after the command
  always @(posedge clk_i)
  begin
    if (slot >= 1 && slot <= 4)
    begin
      wdata_o <= words_i[18*(slot-1) +: 18];
      lanes_n_o <= lanes_n_i[2*(slot-1) +: 2];
    end
    else
    begin
      wdata_o <= ~wdata_o;
      lanes_n_o <= 2'h3;
    end
  end
endmodule : bds_ctrl_model

// File: sim/bds_tb_top.sv
// Self-checking bench for the burst-of-four SRAM command port
`timescale 1ns/1ns
module burst4_ddr_sram_command_port_tb_top;
  localparam logic [71:0] W1 = {18'h0DCBA, 18'h0CAFE, 18'h3BEEF, 18'h01234};
  localparam logic [71:0] W3 = {18'h11111, 18'h22222, 18'h33333, 18'h04444};
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic clk_run_i = 1'b1;
  logic go = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [71:0] words = 72'h0;
  logic [7:0] lanes = 8'hFF;
  logic read_sel_n;
  logic write_sel_n;
  logic [5:0] addr_pin;
  logic [17:0] wdata_pin;
  logic [1:0] lanes_pin;
  logic [17:0] rdata_o;
  logic rdata_oe_o;
  // K edges fall on odd cycle counts once reset is released
  logic p = 1'b1;
  int cyc = 0;
  int fails = 0;
  int cmp_count = 0;

  bds_ctrl_model i_bds_ctrl_model (
    .clk_i(clk_i), .go_i(go), .rd_i(rd), .wr_i(wr), .addr_i(addr),
    .words_i(words), .lanes_n_i(lanes), .read_sel_n_o(read_sel_n),
    .write_sel_n_o(write_sel_n), .addr_o(addr_pin),
    .wdata_o(wdata_pin), .lanes_n_o(lanes_pin)
  );
  bds_sram_port #(.AW(6), .DEPTH(32)) i_bds_sram_port (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .clk_run_i(clk_run_i),
    .read_sel_n_i(read_sel_n), .write_sel_n_i(write_sel_n),
    .addr_i(addr_pin), .wdata_i(wdata_pin),
    .byte_lane0_write_n_i(lanes_pin[0]),
    .byte_lane1_write_n_i(lanes_pin[1]),
    .rdata_o(rdata_o), .rdata_oe_o(rdata_oe_o)
  );

  // Free-running clock
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  // Cycle count; a hang ends the run
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      fails++;
      stop_test();
    end
  end
  // ***************************************************
  // Shared tasks
  // ***************************************************
  task automatic chk(input string nm, input logic [17:0] s,
                     input logic [17:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Land just after an edge of K phase
  task automatic align();
    @(posedge clk_i);
    #1;
    while (cyc[0] !== p)
    begin
      @(posedge clk_i);
      #1;
    end
  endtask : align
  task automatic issue(input logic r, input logic w, input logic [5:0] a,
                       input logic [71:0] d, input logic [7:0] l);
    align();
    go = 1'b1;
    rd = r;
    wr = w;
    addr = a;
    words = d;
    lanes = l;
    @(posedge clk_i);
    #1;
    go = 1'b0;
  endtask : issue
  task automatic wr4(input logic [5:0] a, input logic [71:0] d,
                     input logic [7:0] l);
    issue(1'b0, 1'b1, a, d, l);
    // Words drain through the FIFO before any read
    repeat (24) @(posedge clk_i);
  endtask : wr4
  task automatic rd4(input logic [5:0] a, input logic [71:0] e,
                     input logic w);
    int n;
    n = 0;
    issue(1'b1, w, a, W3, 8'h00);
    while (rdata_oe_o !== 1'b1 && n < 12)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // Two sync edges, then four half cycles
    chk("rd_latency", 18'(n), 18'h6);
    for (int k = 0; k < 4; k++)
    begin
      chk("rdata_oe", {17'h0, rdata_oe_o}, 18'h1);
      chk("rdata", rdata_o, e[18*k +: 18]);
      @(posedge clk_i);
      #1;
    end
    chk("oe_after", {17'h0, rdata_oe_o}, 18'h0);
    repeat (24) @(posedge clk_i);
  endtask : rd4
  // ***************************************************
  // Scenarios
  // ***************************************************
  task automatic t_cal();
    int n;
    n = 0;
    // Command on the K# phase must be refused
    p = 1'b0;
    issue(1'b1, 1'b0, 6'h08, 72'h0, 8'hFF);
    p = 1'b1;
    repeat (12)
    begin
      @(posedge clk_i);
      #1;
      n += (rdata_oe_o === 1'b1);
    end
    chk("oe_k_sharp", 18'(n), 18'h0);
    $display("test phase_find done");
  endtask : t_cal
  task automatic t_rw();
    wr4(6'h08, W1, 8'h00);
    rd4(6'h08, W1, 1'b0);
    $display("test write_read done");
  endtask : t_rw
  task automatic t_lanes();
    // Lane 0 only, lane 1 only, abort, both
    wr4(6'h08, {72{1'b1}}, 8'h36);
    rd4(6'h08, {18'h3FFFF, W1[53:36], 9'h1FF, W1[26:18], W1[17:9],
                9'h1FF}, 1'b0);
    $display("test lanes done");
  endtask : t_lanes
  task automatic t_b2b();
    int n;
    n = 0;
    issue(1'b1, 1'b0, 6'h08, 72'h0, 8'hFF);
    issue(1'b1, 1'b0, 6'h28, 72'h0, 8'hFF);
    repeat (16)
    begin
      @(posedge clk_i);
      #1;
      n += (rdata_oe_o === 1'b1);
    end
    chk("oe_count", 18'(n), 18'h4);
    wr4(6'h14, W1, 8'h00);
    issue(1'b0, 1'b1, 6'h10, W3, 8'h00);
    wr4(6'h14, W3, 8'h00);
    rd4(6'h14, W1, 1'b0);
    $display("test back_to_back done");
  endtask : t_b2b
  task automatic t_collide();
    // Read and write together after idle: write dropped
    rd4(6'h14, W1, 1'b1);
    $display("test collide done");
  endtask : t_collide
  task automatic t_stop();
    logic [17:0] held;
    held = rdata_o;
    align();
    clk_run_i = 1'b0;
    issue(1'b1, 1'b0, 6'h08, 72'h0, 8'hFF);
    repeat (10)
    begin
      @(posedge clk_i);
      #1;
      chk("oe_stopped", {17'h0, rdata_oe_o}, 18'h0);
    end
    chk("rdata_held", rdata_o, held);
    // Even stop length keeps the K phase
    align();
    clk_run_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rd4(6'h14, W1, 1'b0);
    $display("test clock_stop done");
  endtask : t_stop
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    t_cal();
    t_rw();
    t_lanes();
    t_b2b();
    t_collide();
    t_stop();
    stop_test();
  end
endmodule : burst4_ddr_sram_command_port_tb_top
